/* File: design/interp_mixer.sv */
// sample fifo plus the interpolating filter, coarse mixer and offset datapath
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/100ps

module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [PW:0]      next_level;
  logic             push;
  logic             pop;

  assign in_ready  = (level != (PW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_level  = level + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level  <= next_level;
    end
  end

  // storage carries no reset; only written entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// Overview of operation
// R1: half-band 59 taps, sinc taps 1,-5,264,-5,1
// R2: mixer lives in interpolator, needs it enabled
// R3: A real, B imaginary, complex rotation
// R4: codes: none, half, plus quarter, minus quarter
// R5: quarter-rate sequences swap and negate channels
// R6: half-rate alternates sign, channels stay independent
// R7: half-rate turns filter into high-pass
// R8: low-pass keeps band, high-pass inverts it
// R9: per-channel 13-bit signed offset, four registers
// R10: commit write loads all offsets together
// R11: other offset writes only touch staging
// R12: software writes commit register last
// R13: offset added LSB-aligned before output
// R14: source backs off amplitude to avoid clipping
// R15: sinc filter first, needs both enabled
// R16: sinc runs at input rate, half output
// R17: filters and adder saturate to 16 bits
// R18: mixer index steps per output, wraps, resets
module interp_mixer
  import interp_mixer_pkg::*;
(
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // de-interleaved input samples
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire sample_pair_t               in_data,
  // converter-rate output
  output logic                            out_valid,
  output sample_pair_t                    out_data
);
  logic [3:0]                  ctrl;
  logic [OFFSET_W-1:0]         stage_a;
  logic [OFFSET_W-1:0]         stage_b;
  logic signed [OFFSET_W-1:0]  active_a;
  logic signed [OFFSET_W-1:0]  active_b;
  logic [3:0]                  next_ctrl;
  logic [OFFSET_W-1:0]         next_stage_a;
  logic [OFFSET_W-1:0]         next_stage_b;
  logic [OFFSET_W-1:0]         next_active_a;
  logic [OFFSET_W-1:0]         next_active_b;
  logic                        wr_en;
  logic                        mapped;

  sample_pair_t                fifo_data;
  logic                        fifo_valid;
  logic [3:0]                  fifo_level;
  logic                        pop;
  logic                        phase;
  logic                        primed;
  logic [1:0]                  mix_idx;
  sample_pair_t                sinc_line [5];
  sample_pair_t                hb_line [HB_LEN];
  logic                        next_phase;
  logic                        next_primed;
  logic [1:0]                  next_mix_idx;
  logic                        next_out_valid;
  sample_pair_t                next_out_data;
  logic                        interp_on;
  logic                        sinc_on;
  mix_mode_t                   mode;
  sample_pair_t                sinc_out;
  sample_pair_t                hb_in;
  sample_pair_t                filt;
  sample_pair_t                mix;

  function automatic logic signed [SAMPLE_W-1:0] sat16(input logic signed [ACC_W-1:0] v);
    if (v > ACC_W'(32767)) begin
      sat16 = 16'sh7fff;
    end else if (v < -ACC_W'(32768)) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = v[SAMPLE_W-1:0];
    end
  endfunction

  function automatic logic signed [SAMPLE_W-1:0] neg16(input logic signed [SAMPLE_W-1:0] v);
    neg16 = sat16(-ACC_W'(v)); // R17
  endfunction

  // register access: no wait states, errors on unmapped words
  assign wr_en   = psel && penable && pwrite;
  assign mapped  = paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_OFS_A_LO, ADDR_OFS_A_HI,
                                 ADDR_OFS_B_LO, ADDR_OFS_B_HI, ADDR_ACTIVE};
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      ADDR_CTRL:     prdata = {28'h0, ctrl};
      ADDR_STATUS:   prdata = {26'h0, out_valid, fifo_level, primed};
      ADDR_OFS_A_LO: prdata = {24'h0, stage_a[7:0]};
      ADDR_OFS_A_HI: prdata = {27'h0, stage_a[12:8]};
      ADDR_OFS_B_LO: prdata = {24'h0, stage_b[7:0]};
      ADDR_OFS_B_HI: prdata = {27'h0, stage_b[12:8]};
      ADDR_ACTIVE:   prdata = {3'h0, active_b, 3'h0, active_a};
      default:       prdata = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_ctrl     = ctrl;
    next_stage_a  = stage_a;
    next_stage_b  = stage_b;
    next_active_a = active_a;
    next_active_b = active_b;
    if (wr_en) begin
      case (paddr)
        ADDR_CTRL:     next_ctrl = pwdata[3:0];
        ADDR_OFS_A_HI: next_stage_a[12:8] = pwdata[4:0]; // R11
        ADDR_OFS_B_LO: next_stage_b[7:0] = pwdata[7:0]; // R11
        ADDR_OFS_B_HI: next_stage_b[12:8] = pwdata[4:0]; // R11
        ADDR_OFS_A_LO: begin
          // the low half of A is the commit register; it loads both channels at once
          next_stage_a[7:0] = pwdata[7:0];
          next_active_a     = {stage_a[12:8], pwdata[7:0]}; // R9 R10
          next_active_b     = stage_b; // R10 R12
        end
        default: next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl     <= CTRL_RESET;
      stage_a  <= OFFSET_RESET;
      stage_b  <= OFFSET_RESET;
      active_a <= OFFSET_RESET;
      active_b <= OFFSET_RESET;
    end else begin
      ctrl     <= next_ctrl;
      stage_a  <= next_stage_a;
      stage_b  <= next_stage_b;
      active_a <= next_active_a;
      active_b <= next_active_b;
    end
  end

  // input side: one pair every other clock, so output runs at twice the input rate
  sample_fifo #(.WIDTH($bits(sample_pair_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_data),
    .out_valid (fifo_valid),
    .out_ready (!phase),
    .out_data  (fifo_data),
    .level     (fifo_level)
  );
  assign pop = fifo_valid && !phase; // R16

  assign interp_on = ctrl[CTRL_INTERP_BIT];
  assign sinc_on   = interp_on && ctrl[CTRL_SINC_BIT]; // R15
  assign mode      = interp_on ? mix_mode_t'(ctrl[CTRL_MIX_LSB +: 2]) : MIX_NONE; // R2

  always_comb begin
    logic signed [ACC_W-1:0] acc_a;
    logic signed [ACC_W-1:0] acc_b;
    acc_a = ACC_W'(SINC_OUTER) * (ACC_W'(sinc_line[0].a) + ACC_W'(sinc_line[4].a))
          + ACC_W'(SINC_NEAR) * (ACC_W'(sinc_line[1].a) + ACC_W'(sinc_line[3].a))
          + ACC_W'(SINC_MID) * ACC_W'(sinc_line[2].a); // R1
    acc_b = ACC_W'(SINC_OUTER) * (ACC_W'(sinc_line[0].b) + ACC_W'(sinc_line[4].b))
          + ACC_W'(SINC_NEAR) * (ACC_W'(sinc_line[1].b) + ACC_W'(sinc_line[3].b))
          + ACC_W'(SINC_MID) * ACC_W'(sinc_line[2].b); // R1
    sinc_out.a = sat16(acc_a >>> SINC_SHIFT); // R17
    sinc_out.b = sat16(acc_b >>> SINC_SHIFT); // R17
    hb_in = sinc_on ? sinc_out : sinc_line[0]; // R15
  end

  // half-band: even phase is the symmetric tap sum, odd phase the center tap alone
  always_comb begin
    logic signed [ACC_W-1:0] acc_a;
    logic signed [ACC_W-1:0] acc_b;
    acc_a = '0;
    acc_b = '0;
    for (int k = 0; k < HB_HALF; k++) begin
      acc_a += ACC_W'(HB_COEF[k]) * (ACC_W'(hb_line[k].a) + ACC_W'(hb_line[HB_LEN-1-k].a));
      acc_b += ACC_W'(HB_COEF[k]) * (ACC_W'(hb_line[k].b) + ACC_W'(hb_line[HB_LEN-1-k].b));
    end
    if (!interp_on) begin
      filt = hb_line[0];
    end else if (!phase) begin
      filt.a = sat16(acc_a >>> HB_SHIFT); // R1 R17
      filt.b = sat16(acc_b >>> HB_SHIFT);
    end else begin
      filt.a = sat16((ACC_W'(HB_CENTER) * ACC_W'(hb_line[HB_HALF].a)) >>> HB_SHIFT); // R1
      filt.b = sat16((ACC_W'(HB_CENTER) * ACC_W'(hb_line[HB_HALF].b)) >>> HB_SHIFT);
    end
  end

  // coarse mixer: A is the real part, B the imaginary part
  always_comb begin
    mix = filt;
    case (mode)
      MIX_NONE: mix = filt; // R4 R8
      MIX_HALF: begin
        // alternate samples inverted: high-pass image, channels never cross
        mix.a = mix_idx[0] ? neg16(filt.a) : filt.a; // R6 R7 R8
        mix.b = mix_idx[0] ? neg16(filt.b) : filt.b; // R6
      end
      MIX_QPOS: begin
        case (mix_idx)
          2'h0: mix = filt; // R3 R5
          2'h1: begin
            mix.a = neg16(filt.b); // R5
            mix.b = filt.a;
          end
          2'h2: begin
            mix.a = neg16(filt.a); // R5
            mix.b = neg16(filt.b);
          end
          default: begin
            mix.a = filt.b; // R5
            mix.b = neg16(filt.a);
          end
        endcase
      end
      MIX_QNEG: begin
        case (mix_idx)
          2'h0: mix = filt; // R3 R5
          2'h1: begin
            mix.a = filt.b; // R5
            mix.b = neg16(filt.a);
          end
          2'h2: begin
            mix.a = neg16(filt.a); // R5
            mix.b = neg16(filt.b);
          end
          default: begin
            mix.a = neg16(filt.b); // R5
            mix.b = filt.a;
          end
        endcase
      end
      default: mix = filt;
    endcase
  end

  always_comb begin
    next_phase     = !phase;
    next_primed    = phase ? primed : fifo_valid;
    next_out_valid = primed;
    next_mix_idx   = primed ? mix_idx + 2'h1 : mix_idx; // R18
    // offset is sign-extended from bit 12 upward, then clipped, never wrapped
    next_out_data.a = sat16(ACC_W'(mix.a) + ACC_W'(active_a)); // R13 R17
    next_out_data.b = sat16(ACC_W'(mix.b) + ACC_W'(active_b)); // R13 R17
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase     <= 1'b0;
      primed    <= 1'b0;
      mix_idx   <= 2'h0; // R18
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      phase     <= next_phase;
      primed    <= next_primed;
      mix_idx   <= next_mix_idx;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
  end

  // delay lines shift only on a pop; cleared so taps start from silence, not unknowns
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sinc_line <= '{default: '0};
      hb_line   <= '{default: '0};
    end else if (pop) begin
      sinc_line[0] <= fifo_data;
      for (int i = 1; i < 5; i++) begin
        sinc_line[i] <= sinc_line[i-1];
      end
      hb_line[0] <= hb_in;
      for (int i = 1; i < HB_LEN; i++) begin
        hb_line[i] <= hb_line[i-1];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  commit_load_a: assert property (wr_en && paddr == ADDR_OFS_A_LO |=> // R10
    active_a == {$past(stage_a[12:8]), $past(pwdata[7:0])} && active_b == $past(stage_b))
    else $error("commit write did not load both offsets");
  stage_hold_a: assert property (wr_en && paddr != ADDR_OFS_A_LO |=> // R11
    $stable(active_a) && $stable(active_b))
    else $error("staging write changed active offset");
  mix_gate_a: assert property (!ctrl[CTRL_INTERP_BIT] |-> mix == hb_line[0]) // R2
    else $error("mixer active with interpolator off");
  sinc_gate_a: assert property (!ctrl[CTRL_INTERP_BIT] |-> hb_in == sinc_line[0]) // R15
    else $error("sinc filter on without both enables");
  idx_step_a: assert property (primed |=> mix_idx == $past(mix_idx) + 2'h1) // R18
    else $error("mixer index did not advance");
  pop_rate_a: assert property (pop |=> !pop ##1 1'b1) // R16
    else $error("input consumed faster than half rate");
  half_flip_a: assert property (mode == MIX_HALF && mix_idx[0] |-> // R6
    mix.a == neg16(filt.a) && mix.b == neg16(filt.b))
    else $error("half-rate sign not alternated");
  qpos_seq_a: assert property (mode == MIX_QPOS && mix_idx == 2'h1 |-> // R5
    mix.a == neg16(filt.b) && mix.b == filt.a)
    else $error("plus quarter sequence wrong");
  offset_add_a: assert property (1'b1 |=> // R13
    out_data.a == sat16(ACC_W'($past(mix.a)) + ACC_W'($past(active_a))))
    else $error("offset not added to channel a");

  qneg_seen_c: cover property (mode == MIX_QNEG && primed [*4]);
  fifo_full_c: cover property (!in_ready);
  commit_c:    cover property (wr_en && paddr == ADDR_OFS_A_LO ##2 out_valid);
endmodule

/* File: shared/interp_mixer_pkg.sv */
// shared constants and types for the dual-channel interpolating mixer datapath
package interp_mixer_pkg;
  localparam int SAMPLE_W   = 16;
  localparam int OFFSET_W   = 13;
  localparam int FIFO_DEPTH = 8;
  localparam int HB_LEN     = 30;
  localparam int HB_HALF    = 15;
  localparam int HB_SHIFT   = 15;
  localparam int SINC_SHIFT = 8;
  localparam int ACC_W      = 40;

  // outer half-band taps, outermost first; odd taps are zero, center is 32768
  localparam int HB_COEF [HB_HALF] = '{4, -12, 28, -58, 108, -188, 308, -483, 734,
                                        -1091, 1607, -2392, 3732, -6681, 20768};
  localparam int HB_CENTER = 32768;
  localparam int SINC_OUTER = 1;
  localparam int SINC_NEAR  = -5;
  localparam int SINC_MID   = 264;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_OFS_A_LO  = 8'h10;
  localparam logic [7:0] ADDR_OFS_A_HI  = 8'h14;
  localparam logic [7:0] ADDR_OFS_B_LO  = 8'h18;
  localparam logic [7:0] ADDR_OFS_B_HI  = 8'h1c;
  localparam logic [7:0] ADDR_ACTIVE    = 8'h20;

  // control field positions and reset value
  localparam int CTRL_INTERP_BIT = 0;
  localparam int CTRL_SINC_BIT   = 1;
  localparam int CTRL_MIX_LSB    = 2;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [OFFSET_W-1:0] OFFSET_RESET = 13'h0000;

  typedef enum logic [1:0] {MIX_NONE, MIX_HALF, MIX_QPOS, MIX_QNEG} mix_mode_t;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] a;
    logic signed [SAMPLE_W-1:0] b;
  } sample_pair_t;
endpackage

/* File: tb/stream_partner.sv */
// input path source and converter-core sink around the datapath
`timescale 1ns/100ps
module stream_partner
  import interp_mixer_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // source side
  output logic              in_valid,
  input  wire logic         in_ready,
  output sample_pair_t      in_data,
  // sink side
  input  wire logic         out_valid,
  input  wire sample_pair_t out_data
);
  sample_pair_t txq [$];
  sample_pair_t rxq [$];
  bit           stall_en;
  bit           saw_full;

  initial begin
    in_valid = 1'b0;
    in_data  = '0;
    stall_en = 1'b1;
    saw_full = 1'b0;
  end

  // a pair is held until taken; idle data is scrambled so stale words never pass
  always @(posedge clk) begin
    if (in_valid && in_ready)
      void'(txq.pop_front());
    if (in_valid && !in_ready)
      saw_full <= 1'b1;
    if (reset) begin
      in_valid <= 1'b0;
    end else if (!in_valid || in_ready) begin
      if (txq.size() != 0 && (!stall_en || $urandom_range(3) != 0)) begin
        in_valid <= 1'b1;
        in_data  <= txq[0];
      end else begin
        in_valid <= 1'b0;
        in_data  <= ~in_data;
      end
    end
  end

  // converter cores take every strobed sample, no back-pressure
  always @(posedge clk) begin
    if (out_valid === 1'b1)
      rxq.push_back(out_data);
  end
endmodule

/* File: tb/test_dual_chan_interp_mixer_offset.sv */
// self-checking bench for the interpolating mixer and offset datapath
`timescale 1ns/100ps
module test_dual_chan_interp_mixer_offset
  import interp_mixer_pkg::*;
();
  logic         clk = 1'b0;
  logic         reset = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = '0;
  logic [31:0]  pwdata = '0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         in_valid;
  logic         in_ready;
  sample_pair_t in_data;
  logic         out_valid;
  sample_pair_t out_data;
  int           errors = 0;
  int           check_count = 0;
  logic [31:0]  rd;
  logic         er;

  always #10 clk = ~clk;

  interp_mixer uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
    .out_data(out_data));
  stream_partner partner (.clk(clk), .reset(reset), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .out_valid(out_valid), .out_data(out_data));

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_pair(input sample_pair_t got, input sample_pair_t exp);
    check_word(got, exp);
  endtask

  // one idle cycle between transfers keeps every strobe single-driven per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stage(input logic [12:0] a, input logic [12:0] b);
    apb(1'b1, ADDR_OFS_A_HI, {27'h0, a[12:8]});
    apb(1'b1, ADDR_OFS_B_LO, {24'h0, b[7:0]});
    apb(1'b1, ADDR_OFS_B_HI, {27'h0, b[12:8]});
  endtask

  task automatic set_ofs(input logic [12:0] a, input logic [12:0] b);
    stage(a, b);
    apb(1'b1, ADDR_OFS_A_LO, {24'h0, a[7:0]});
  endtask

  function automatic logic [15:0] sat16(input int v);
    if (v > 32767)
      return 16'h7fff;
    if (v < -32768)
      return 16'h8000;
    return v[15:0];
  endfunction

  function automatic sample_pair_t mix_exp(input mix_mode_t m, input int k, input int a,
                                           input int b);
    int t [4][2];
    case (m)
      MIX_NONE: t = '{'{a, b}, '{a, b}, '{a, b}, '{a, b}};
      MIX_HALF: t = '{'{a, b}, '{-a, -b}, '{a, b}, '{-a, -b}};
      MIX_QPOS: t = '{'{a, b}, '{-b, a}, '{-a, -b}, '{b, -a}};
      default:  t = '{'{a, b}, '{b, -a}, '{-a, -b}, '{-b, a}};
    endcase
    return {sat16(t[k % 4][0]), sat16(t[k % 4][1])};
  endfunction

  task automatic wait_out(input int n);
    int w;
    w = 0;
    while (partner.rxq.size() < n && w < 3000) begin
      @(posedge clk);
      w++;
    end
    repeat (4) @(posedge clk);
    check_word(32'(partner.rxq.size()), 32'(n));
  endtask

  task automatic test_regs();
    logic [7:0] addrs [7];
    addrs = '{ADDR_CTRL, ADDR_STATUS, ADDR_OFS_A_LO, ADDR_OFS_A_HI, ADDR_OFS_B_LO,
              ADDR_OFS_B_HI, ADDR_ACTIVE};
    foreach (addrs[i]) begin
      apb(1'b0, addrs[i], 32'h0);
      check_word(rd, 32'h0);
    end
    apb(1'b1, 8'h30, 32'h5);
    check_word({31'h0, er}, 32'h1);
    apb(1'b0, 8'h30, 32'h0);
    check_word({rd[30:0], er}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'hd);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check_word(rd, 32'hd);
    $display("test regs done, errors %0d", errors);
  endtask

  task automatic test_commit();
    logic [12:0] c;
    logic [12:0] d;
    c = 13'($urandom);
    d = 13'($urandom);
    set_ofs(13'h0fff, 13'h1000);
    apb(1'b0, ADDR_ACTIVE, 32'h0);
    check_word(rd, 32'h1000_0fff);
    stage(c, d);
    apb(1'b0, ADDR_ACTIVE, 32'h0);
    check_word(rd, 32'h1000_0fff);
    apb(1'b1, ADDR_OFS_A_LO, {24'h0, c[7:0]});
    apb(1'b0, ADDR_ACTIVE, 32'h0);
    check_word(rd, {3'h0, d, 3'h0, c});
    $display("test commit done, errors %0d", errors);
  endtask

  // bypass: mixer code and sinc bit must both be ignored
  task automatic test_plain();
    sample_pair_t sent [$];
    sample_pair_t s;
    set_ofs(13'h0fff, 13'h1000);
    apb(1'b1, ADDR_CTRL, {28'h0, MIX_QPOS, 1'b1, 1'b0});
    partner.rxq.delete();
    sent = '{{16'h7fff, 16'h8000}, {16'h8000, 16'h7fff}};
    repeat (20) begin
      s = $urandom;
      s.a = s.a >>> 1;
      s.b = s.b >>> 1;
      sent.push_back(s);
    end
    foreach (sent[i])
      partner.txq.push_back(sent[i]);
    wait_out(2 * sent.size());
    // bypass lags one pair; the first slot shows the cleared delay line
    s = '0;
    foreach (sent[i]) begin
      for (int j = 0; j < 2; j++)
        check_pair(partner.rxq[2 * i + j], {sat16(s.a + 4095), sat16(s.b - 4096)});
      s = sent[i];
    end
    $display("test plain done, errors %0d", errors);
  endtask

  // dc input: unity gain of both filters makes the mixer sequence visible
  task automatic test_mix(input mix_mode_t m, input logic sinc);
    int a;
    int b;
    int k;
    int base;
    a = 1000 + $urandom_range(7000);
    b = -9000 - $urandom_range(7000);
    apb(1'b1, ADDR_CTRL, {28'h0, m, sinc, 1'b1});
    partner.rxq.delete();
    partner.saw_full = 1'b0;
    repeat (48) partner.txq.push_back({a[15:0], b[15:0]});
    wait_out(96);
    check_word({31'h0, partner.saw_full}, 32'h1);
    base = 80;
    k = 0;
    for (int j = 0; j < 4; j++)
      if (partner.rxq[base] === mix_exp(m, j, a, b))
        k = j;
    for (int j = 0; j < 16; j++)
      check_pair(partner.rxq[base + j], mix_exp(m, k + j, a, b));
    $display("test mix %0d done, errors %0d", m, errors);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    void'($urandom(32'h89ad));
    test_regs();
    test_commit();
    test_plain();
    set_ofs(13'h0, 13'h0);
    for (int i = 0; i < 4; i++) begin
      partner.stall_en = i[1];
      test_mix(mix_mode_t'(i), i[0]);
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    check_word(rd, 32'h0);
    wrap_up();
  end

  // whole run is well under a thousand cycles; this limit of 20000 cycles is far past it
  initial begin
    #400000;
    errors++;
    wrap_up();
  end
endmodule
